// ---- verilog/pwm_sync_pkg.sv ----
// Shared constants of the buffered-update PWM sync block
package pwm_sync_pkg;
    // Register byte offsets
    localparam logic [5:0] CTRL_OFS   = 6'h00;
    localparam logic [5:0] SYNC_OFS   = 6'h04;
    localparam logic [5:0] BUF_FIRST  = 6'h08;
    localparam logic [5:0] BUF_LAST   = 6'h24;
    localparam logic [5:0] MASK_OFS   = 6'h28;
    localparam logic [5:0] STAT_OFS   = 6'h2c;
    // Buffered value slots (low byte at 0x08+8*slot, high byte +4)
    localparam int MOD_IDX   = 0;
    localparam int START_IDX = 1;
    localparam int MATCH0    = 2;
    localparam int NUM_BUF   = 4;
    // Control register fields
    localparam int CLKSEL_LSB = 0;
    localparam int EXTEN_BIT  = 2;
    localparam int CENTER_BIT = 3;
    localparam int JOIN_BIT   = 4;
    localparam int INV_BIT    = 5;
    localparam int OCM_LSB    = 6;
    localparam int PRESC_LSB  = 8;
    // Sync register fields
    localparam int BOTTOM_BIT  = 0;
    localparam int TOP_BIT     = 1;
    localparam int RESTART_BIT = 2;
    localparam int MSKSEL_BIT  = 3;
    localparam int SOFT_BIT    = 4;
    localparam int HWEN_LSB    = 5;
    localparam int VSEN_LSB    = 8;
    // Values after reset, and the counter step of one
    localparam logic [15:0] VALUE_RST = 16'h0000;
    localparam logic [1:0]  CLKSEL_OFF = 2'h0;
    localparam logic [7:0]  PRESC_RST  = 8'h00;
    localparam logic [15:0] ONE16      = 16'h0001;
endpackage

// ---- verilog/trigger_edge_sync.sv ----
// Two-flop synchroniser and rising-edge detector for the trigger inputs
module trigger_edge_sync (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       resetn,
    // Asynchronous trigger pins
    input  wire logic [2:0] trigIn,
    // One-cycle rising-edge pulses
    output logic      [2:0] trigEdge
);
    typedef struct packed {
        logic [2:0] meta;
        logic [2:0] synced;
        logic [2:0] prev;
    } edge_state_t;

    edge_state_t cur;
    edge_state_t next_cur;

    // Meta stage feeds only the second stage
    always_comb begin
        next_cur        = cur;
        next_cur.meta   = trigIn;
        next_cur.synced = cur.meta;
        next_cur.prev   = cur.synced;
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    // Edge is synced level high now, low one cycle ago
    assign trigEdge = cur.synced & ~cur.prev;
endmodule

// ---- verilog/pwm_buffered_update_sync.sv ----
// Buffered register loading, PWM sync and paired outputs of a PWM timer
// How it works
// - Joined pair, extended on, edge aligned, invert set: odd output inverts even.
// - Same setup with invert clear: odd output copies even output.
// - Counter start value loads once both its bytes are written.
// - Clock source off: modulo and match load when second byte is written.
// - Clock running and extended on: modulo and match load only by sync.
// - Extended off, edge aligned: load after both bytes, at counter wrap.
// - Extended off, center aligned: load when counter steps modulo to modulo-1.
// - Output compare channel: match loads at next counter step.
// - Sync loads modulo and match, may restart counter and update mask.
// - Three trigger pins synchronised; enabled rising edge starts sync.
// - Trigger enable clears on write of 0 or when its sync completes.
// - Trigger edge with a write setting its enable: sync, enable stays.
// - Soft request starts sync; clears by write 0 or completion; set wins.
// - Load-at-bottom boundary is reaching the counter start value.
// - Load-at-top boundary is stepping from modulo-1 to modulo.
// - No boundary selected: no sync load unless restart set; both selected: first one wins.
// - Boundary select bits change only by software writes.
// - Without restart, sync loads at next boundary and clears its trigger.
// - With restart, sync loads at the trigger and clears its trigger bit.
// - Match syncs only when both bytes written and its sync enable set.
// - Mask copies every cycle, or waits for sync when mask sync selected.
//
// Design decisions made here: register access over Avalon-MM and the address map.
module pwm_buffered_update_sync
    import pwm_sync_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        resetn,
    // Avalon-MM slave
    input  wire logic [5:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    // Hardware sync triggers
    input  wire logic [2:0]  trigIn,
    // Channel outputs
    output logic      [1:0]  pwmOut
);
    typedef struct packed {
        logic                 waitReq;
        logic [31:0]          rdata;
        logic [1:0]           clkSel;
        logic                 extEn;
        logic                 centerSel;
        logic                 pairJoin;
        logic                 pairInv;
        logic [1:0]           ocMode;
        logic [2:0]           presc;
        logic                 loadBottom;
        logic                 loadTop;
        logic                 restart;
        logic                 maskSel;
        logic                 softReq;
        logic [2:0]           hwEn;
        logic [1:0]           valSyncEn;
        logic                 softPend;
        logic [2:0]           hwPend;
        logic [NUM_BUF-1:0][15:0] wbuf;
        logic [NUM_BUF-1:0][15:0] act;
        logic [NUM_BUF-1:0]   loW;
        logic [NUM_BUF-1:0]   hiW;
        logic [7:0]           prescCnt;
        logic [15:0]          count;
        logic                 down;
        logic [1:0]           maskBuf;
        logic [1:0]           maskAct;
        logic [1:0]           pwm;
    } state_t;

    state_t     cur;
    state_t     next_cur;
    logic [2:0] hwEdge;

    // Pins cross into the core clock before any logic sees them
    trigger_edge_sync trigSync (
        .core_clk (core_clk),
        .resetn   (resetn),
        .trigIn   (trigIn),
        .trigEdge (hwEdge)
    );

    // Buffered byte register decode, used for both reads and writes
    function automatic logic isBuf(input logic [5:0] a);
        return (a >= BUF_FIRST) && (a <= BUF_LAST) && (a[1:0] == 2'h0);
    endfunction

    // Slot of a buffered byte; its high byte sits 4 above
    function automatic logic [1:0] bufSlot(input logic [5:0] a);
        logic [5:0] rel;
        rel = a - BUF_FIRST;
        return rel[4:3];
    endfunction

    // Terms of the single next-state process
    logic              access;
    logic              wrDone;
    logic              syncWr;
    logic              softSet;
    logic [2:0]        effEn;
    logic [2:0]        hwFire;
    logic              anyPend;
    logic              tick;
    logic [7:0]        prescMask;
    logic              topEv;
    logic              bottomEv;
    logic              wrapEv;
    logic              topDownEv;
    logic              boundary;
    logic              syncNow;
    logic              doneSoft;
    logic [2:0]        doneHw;
    logic              clkOff;
    logic              oddLinked;
    logic [1:0]        rawOut;
    logic [NUM_BUF-1:0] complete;
    logic [NUM_BUF-1:0] load;

    always_comb begin
        next_cur  = cur;
        access    = (read | write) & cur.waitReq;
        wrDone    = write & ~cur.waitReq;
        syncWr    = wrDone && (address == SYNC_OFS) && byteenable[0];
        softSet   = syncWr && writedata[SOFT_BIT];
        clkOff    = (cur.clkSel == CLKSEL_OFF);
        complete  = cur.loW & cur.hiW;

        // One wait state, then the transfer completes
        next_cur.waitReq = ~access;

        // Prescaler gives the counter its step enable
        // Idle while no clock source is chosen
        prescMask = 8'((9'h001 << cur.presc) - 9'h001);
        tick      = !clkOff && ((cur.prescCnt & prescMask) == prescMask);
        if (!clkOff) begin
            next_cur.prescCnt = cur.prescCnt + 8'h01;
        end

        // Counter boundary events, seen on the step that makes them
        // Top event is the step into modulo in both modes
        wrapEv    = tick && !cur.centerSel && (cur.count == cur.act[MOD_IDX]);
        topDownEv = tick && cur.centerSel && !cur.down
                    && (cur.count == cur.act[MOD_IDX]);
        topEv     = tick && !cur.down
                    && (cur.count == cur.act[MOD_IDX] - ONE16);
        bottomEv  = cur.centerSel
                    ? (tick && cur.down
                       && (cur.count == cur.act[START_IDX] + ONE16))
                    : wrapEv;

        // Trigger events; an enable written this cycle already counts
        // Pending bits hold a trigger until its boundary
        effEn   = syncWr ? (cur.hwEn | writedata[HWEN_LSB +: 3]) : cur.hwEn;
        hwFire  = hwEdge & effEn;
        anyPend = cur.softPend | (|cur.hwPend);
        boundary = (cur.loadTop && topEv)
                   || (cur.loadBottom && bottomEv);

        // Restart: act on the trigger; otherwise wait for a boundary
        if (cur.restart) begin
            syncNow  = softSet || (|hwFire);
            doneSoft = softSet;
            doneHw   = hwFire;
        end else begin
            syncNow  = boundary && anyPend;
            doneSoft = boundary && cur.softPend;
            doneHw   = boundary ? cur.hwPend : 3'h0;
            next_cur.softPend = (cur.softPend & ~boundary) | softSet;
            next_cur.hwPend   = (cur.hwPend & ~{3{boundary}}) | hwFire;
        end

        // Counter runs up, or up and down in center mode
        if (cur.restart && syncNow && cur.extEn) begin
            next_cur.count = cur.act[START_IDX];
            next_cur.down  = 1'b0;
            // Prescaler restarts too, so the first count is full
            next_cur.prescCnt = PRESC_RST;
        end else if (tick) begin
            if (!cur.centerSel) begin
                next_cur.count = (cur.count == cur.act[MOD_IDX])
                                 ? cur.act[START_IDX]
                                 : cur.count + ONE16;
                next_cur.down  = 1'b0;
            end else if (!cur.down) begin
                if (cur.count == cur.act[MOD_IDX]) begin
                    next_cur.down  = 1'b1;
                    next_cur.count = cur.count - ONE16;
                end else begin
                    next_cur.count = cur.count + ONE16;
                end
            end else begin
                if (cur.count == cur.act[START_IDX]) begin
                    next_cur.down  = 1'b0;
                    next_cur.count = cur.count + ONE16;
                end else begin
                    next_cur.count = cur.count - ONE16;
                end
            end
        end

        // Load decision for every buffered value
        // A byte written during a load sets its flag again
        load[START_IDX] = complete[START_IDX];
        if (clkOff) begin
            load[MOD_IDX] = complete[MOD_IDX];
        end else if (cur.extEn) begin
            load[MOD_IDX] = complete[MOD_IDX] && syncNow;
        end else begin
            load[MOD_IDX] = complete[MOD_IDX]
                            && (cur.centerSel ? topDownEv : wrapEv);
        end
        for (int j = 0; j < 2; j++) begin
            if (clkOff) begin
                load[MATCH0+j] = complete[MATCH0+j];
            end else if (cur.extEn) begin
                load[MATCH0+j] = complete[MATCH0+j] && syncNow
                                 && cur.valSyncEn[j];
            end else if (cur.ocMode[j]) begin
                load[MATCH0+j] = complete[MATCH0+j] && tick;
            end else begin
                load[MATCH0+j] = complete[MATCH0+j]
                                 && (cur.centerSel ? topDownEv : wrapEv);
            end
        end
        for (int i = 0; i < NUM_BUF; i++) begin
            if (load[i]) begin
                next_cur.act[i] = cur.wbuf[i];
                next_cur.loW[i] = 1'b0;
                next_cur.hiW[i] = 1'b0;
            end
        end

        // Output mask: every edge, or only on sync
        if (!cur.maskSel || (syncNow && cur.extEn)) begin
            next_cur.maskAct = cur.maskBuf;
        end

        // Trigger bits clear when their sync completes
        if (doneSoft) begin
            next_cur.softReq = 1'b0;
        end
        next_cur.hwEn = cur.hwEn & ~doneHw;

        // Register writes; a set written now beats the completion clear
        // Writes come last so software has the final say
        if (wrDone && byteenable[0]) begin
            if (address == CTRL_OFS) begin
                next_cur.clkSel    = writedata[CLKSEL_LSB +: 2];
                next_cur.extEn     = writedata[EXTEN_BIT];
                next_cur.centerSel = writedata[CENTER_BIT];
                next_cur.pairJoin  = writedata[JOIN_BIT];
                next_cur.pairInv   = writedata[INV_BIT];
                next_cur.ocMode    = writedata[OCM_LSB +: 2];
            end
            if (syncWr) begin
                next_cur.loadBottom = writedata[BOTTOM_BIT];
                next_cur.loadTop    = writedata[TOP_BIT];
                next_cur.restart    = writedata[RESTART_BIT];
                next_cur.maskSel    = writedata[MSKSEL_BIT];
                next_cur.hwEn       = writedata[HWEN_LSB +: 3];
                // Restart mode completes the written request at once
                next_cur.softReq    = softSet && !cur.restart;
            end
            if (address == MASK_OFS) begin
                next_cur.maskBuf = writedata[1:0];
            end
            if (isBuf(address)) begin
                if (address[2]) begin
                    next_cur.wbuf[bufSlot(address)][15:8] = writedata[7:0];
                    next_cur.hiW[bufSlot(address)]        = 1'b1;
                end else begin
                    next_cur.wbuf[bufSlot(address)][7:0] = writedata[7:0];
                    next_cur.loW[bufSlot(address)]       = 1'b1;
                end
            end
        end
        if (wrDone && byteenable[1] && (address == CTRL_OFS)) begin
            next_cur.presc = writedata[PRESC_LSB +: 3];
        end
        if (wrDone && byteenable[1] && syncWr) begin
            next_cur.valSyncEn = writedata[VSEN_LSB +: 2];
        end

        // Read data prepared during the wait state
        // Unmapped offsets fall through and read as zero
        next_cur.rdata = 32'h0000_0000;
        if (access && read) begin
            if (address == CTRL_OFS) begin
                next_cur.rdata = {21'h0, cur.presc, cur.ocMode,
                                  cur.pairInv, cur.pairJoin, cur.centerSel,
                                  cur.extEn, cur.clkSel};
            end else if (address == SYNC_OFS) begin
                next_cur.rdata = {22'h0, cur.valSyncEn, cur.hwEn,
                                  cur.softReq, cur.maskSel, cur.restart,
                                  cur.loadTop, cur.loadBottom};
            end else if (address == MASK_OFS) begin
                next_cur.rdata = {28'h0, cur.maskAct, cur.maskBuf};
            end else if (address == STAT_OFS) begin
                next_cur.rdata = {7'h0, complete, cur.hwPend, cur.softPend,
                                  cur.down, cur.count};
            end else if (isBuf(address)) begin
                next_cur.rdata = {24'h0, address[2]
                                  ? cur.act[bufSlot(address)][15:8]
                                  : cur.act[bufSlot(address)][7:0]};
            end
        end

        // Paired channel outputs from active match values
        rawOut[0] = cur.count < cur.act[MATCH0];
        rawOut[1] = cur.count < cur.act[MATCH0+1];
        oddLinked = cur.extEn && cur.pairJoin && !cur.centerSel;
        if (oddLinked) begin
            rawOut[1] = cur.pairInv ? ~rawOut[0] : rawOut[0];
        end
        // Clock off parks both outputs low
        next_cur.pwm = clkOff ? 2'h0 : (rawOut & ~cur.maskAct);
    end

    // Whole state registered in one place
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            cur          <= '0;
            // Bus idles with waitrequest raised
            cur.waitReq  <= 1'b1;
            cur.clkSel   <= CLKSEL_OFF;
            cur.prescCnt <= PRESC_RST;
            cur.count    <= VALUE_RST;
        end else begin
            cur <= next_cur;
        end
    end

    assign readdata    = cur.rdata;
    assign waitrequest = cur.waitReq;
    assign pwmOut      = cur.pwm;
endmodule

// ---- sim/trig_source.sv ----
// Model of the on-chip logic that drives the sync trigger pins
module trig_source (
    // Clock
    input  wire logic       core_clk,
    // Trigger pins
    output logic      [2:0] trigIn
);
    timeunit 1ns;
    timeprecision 1ps;

    // Pins idle low, never left floating
    initial trigIn = 3'h0;

    // Clean pulse, held long enough for the two-flop capture
    task automatic pulse(input int n);
        @(posedge core_clk);
        trigIn[n] <= 1'b1;
        repeat (6) @(posedge core_clk);
        trigIn[n] <= 1'b0;
    endtask
endmodule

// ---- sim/pwm_buffered_update_sync_assertions.sv ----
// Port-level checker of the buffered-update sync block
module pwm_buffered_update_sync_assertions
    import pwm_sync_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        resetn,
    // Register bus
    input  wire logic [5:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    input  wire logic [31:0] readdata,
    input  wire logic        waitrequest,
    // Pins
    input  wire logic [2:0]  trigIn,
    input  wire logic [1:0]  pwmOut
);
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] sync;
        logic [1:0] mask;
    } shadow_t;

    shadow_t sh;
    shadow_t next_sh;
    logic    done;
    logic    pairOn;
    logic [1:0] calm;

    // Shadow of completed writes, lane 0 only
    assign done = write && !waitrequest && byteenable[0];
    always_comb begin
        next_sh = sh;
        if (done && address == CTRL_OFS) next_sh.ctrl = writedata[7:0];
        if (done && address == SYNC_OFS) next_sh.sync = writedata[7:0];
        if (done && address == MASK_OFS) next_sh.mask = writedata[1:0];
    end
    always_ff @(posedge core_clk) begin
        if (!resetn) sh <= '0;
        else sh <= next_sh;
    end
    // Cycles since the shadow last moved; outputs lag by two
    always_ff @(posedge core_clk) begin
        if (!resetn || next_sh != sh) begin
            calm <= 2'h0;
        end else if (calm != 2'h3) begin
            calm <= calm + 2'h1;
        end
    end
    // Mask clear and copied every cycle, else the pair is hidden
    assign pairOn = sh.ctrl[1:0] != 2'h0 && sh.ctrl[2] && sh.ctrl[4]
                    && !sh.ctrl[3] && sh.mask == 2'h0 && !sh.sync[3];

    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);

    a_wait_answer:
        assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("request not answered after one wait state");
    a_wait_single:
        assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_idle_quiet:
        assert property (!(read || write) && waitrequest |=> waitrequest)
        else $error("waitrequest dropped without a request");
    a_data_idle:
        assert property (waitrequest |-> readdata == 32'h0)
        else $error("readdata not zero outside a read answer");
    a_unmapped_zero:
        assert property (read && !waitrequest && address > STAT_OFS
                         |-> readdata == 32'h0)
        else $error("unmapped read returned nonzero data");
    a_bound_kept:
        assert property (read && !waitrequest && address == SYNC_OFS
                         |-> readdata[1:0] == sh.sync[1:0])
        else $error("boundary select bits changed by themselves");
    a_pair_invert:
        assert property (pairOn && calm == 2'h3 && sh.ctrl[5]
                         |-> pwmOut[1] == !pwmOut[0])
        else $error("odd output not inverse of even output");
    a_pair_copy:
        assert property (pairOn && calm == 2'h3 && !sh.ctrl[5]
                         |-> pwmOut[1] == pwmOut[0])
        else $error("odd output differs from even output");

    // Main scenarios reached
    c_pair_inv: cover property (pairOn && sh.ctrl[5]);
    c_trig_rise: cover property ($rose(trigIn[0]));
    c_sync_read: cover property (read && !waitrequest
                                 && address == SYNC_OFS);
endmodule

bind pwm_buffered_update_sync pwm_buffered_update_sync_assertions chk_u (
    .core_clk(core_clk), .resetn(resetn), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .trigIn(trigIn), .pwmOut(pwmOut)
);

// ---- sim/pwm_buffered_update_sync_tb_top.sv ----
// Self-checking bench of the buffered-update sync block
module pwm_buffered_update_sync_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pwm_sync_pkg::*;

    logic        core_clk;
    logic        resetn;
    logic [5:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
    logic [31:0] readdata;
    logic        waitrequest;
    logic [2:0]  trigIn;
    logic [1:0]  pwmOut;
    int          fails;
    int          testsRun;

    // 125 MHz
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    pwm_buffered_update_sync dut_u (
        .core_clk(core_clk), .resetn(resetn), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .trigIn(trigIn), .pwmOut(pwmOut)
    );
    trig_source trg_u (.core_clk(core_clk), .trigIn(trigIn));

    task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chkPin(input logic [1:0] got, input logic [1:0] exp);
        testsRun++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Bus cycles: hold until waitrequest low, one idle edge after
    task automatic bw(input logic [5:0] a, input logic [31:0] d,
                      input logic [3:0] be);
        address <= a;
        writedata <= d;
        byteenable <= be;
        write <= 1'b1;
        do @(posedge core_clk); while (waitrequest !== 1'b0);
        write <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic br(input logic [5:0] a, output logic [31:0] d);
        address <= a;
        read <= 1'b1;
        do @(posedge core_clk); while (waitrequest !== 1'b0);
        d = readdata;
        read <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wv(input int s, input logic [15:0] v);
        bw(6'(BUF_FIRST + 8 * s), {24'h0, v[7:0]}, 4'h1);
        bw(6'(BUF_FIRST + 8 * s + 4), {24'h0, v[15:8]}, 4'h1);
    endtask
    task automatic expv(input int s, input logic [15:0] e);
        logic [31:0] lo;
        logic [31:0] hi;
        br(6'(BUF_FIRST + 8 * s), lo);
        br(6'(BUF_FIRST + 8 * s + 4), hi);
        chkReg({16'h0, hi[7:0], lo[7:0]}, {16'h0, e});
    endtask
    task automatic chkSync(input logic [9:0] e);
        logic [31:0] d;
        br(SYNC_OFS, d);
        chkReg(32'(d[9:0]), 32'(e));
    endtask
    // Counter leaves v and comes back to it; bounded polling
    task automatic waitHit(input logic [15:0] v);
        logic [31:0] d;
        int          n;
        n = 0;
        do begin
            br(STAT_OFS, d);
            n++;
        end while (d[15:0] === v && n < 500);
        do begin
            br(STAT_OFS, d);
            n++;
        end while (d[15:0] !== v && n < 1000);
        chkReg(32'(d[15:0]), 32'(v));
    endtask

    task automatic t_reset;
        logic [31:0] d;
        br(CTRL_OFS, d);
        chkReg(d, 32'h0);
        chkSync(10'h000);
        chkPin(pwmOut, 2'h0);
        bw(6'h30, 32'h000000ff, 4'hf);
        br(6'h30, d);
        chkReg(d, 32'h0);
    endtask
    task automatic t_clock_off;
        bw(6'h08, 32'h02, 4'h1);
        expv(MOD_IDX, 16'h0000);
        bw(6'h0c, 32'h00, 4'h1);
        expv(MOD_IDX, 16'h0002);
        bw(6'h10, 32'h01, 4'h1);
        expv(START_IDX, 16'h0000);
        bw(6'h14, 32'h00, 4'h1);
        expv(START_IDX, 16'h0001);
        wv(START_IDX, 16'h0000);
    endtask
    // Slow prescaler, so each count lasts 128 cycles
    task automatic t_legacy_wrap;
        bw(CTRL_OFS, 32'h0701, 4'h3);
        waitHit(16'h0000);
        wv(MOD_IDX, 16'h0003);
        expv(MOD_IDX, 16'h0002);
        waitHit(16'h0000);
        expv(MOD_IDX, 16'h0003);
    endtask
    task automatic t_ext_hw;
        bw(CTRL_OFS, 32'h0715, 4'h3);
        bw(SYNC_OFS, 32'h00e2, 4'h3);
        wv(MOD_IDX, 16'h0004);
        waitHit(16'h0003);
        expv(MOD_IDX, 16'h0003);
        trg_u.pulse(0);
        waitHit(16'h0003);
        expv(MOD_IDX, 16'h0004);
        chkSync(10'h0c2);
    endtask
    task automatic t_restart;
        logic [31:0] d;
        bw(SYNC_OFS, 32'h06, 4'h1);
        wv(MOD_IDX, 16'h0005);
        bw(SYNC_OFS, 32'h16, 4'h1);
        expv(MOD_IDX, 16'h0005);
        br(STAT_OFS, d);
        chkReg(32'(d[15:0]), 32'h0);
        chkSync(10'h006);
        bw(SYNC_OFS, 32'h86, 4'h1);
        wv(MOD_IDX, 16'h0006);
        trg_u.pulse(2);
        expv(MOD_IDX, 16'h0006);
        chkSync(10'h006);
    endtask
    task automatic t_no_bound;
        bw(SYNC_OFS, 32'h00, 4'h1);
        bw(SYNC_OFS, 32'h10, 4'h1);
        wv(MOD_IDX, 16'h0002);
        waitHit(16'h0000);
        expv(MOD_IDX, 16'h0006);
        chkSync(10'h010);
        bw(SYNC_OFS, 32'h11, 4'h1);
        waitHit(16'h0000);
        expv(MOD_IDX, 16'h0002);
        chkSync(10'h001);
    endtask
    task automatic t_match_sync;
        bw(SYNC_OFS, 32'h06, 4'h1);
        wv(MATCH0, 16'h0009);
        bw(SYNC_OFS, 32'h16, 4'h1);
        expv(MATCH0, 16'h0000);
        bw(SYNC_OFS, 32'h0106, 4'h3);
        bw(SYNC_OFS, 32'h0116, 4'h3);
        expv(MATCH0, 16'h0009);
    endtask
    // Match above modulo keeps the even output high
    task automatic t_pair;
        bw(CTRL_OFS, 32'h0035, 4'h3);
        repeat (4) @(posedge core_clk);
        chkPin(pwmOut, 2'h1);
        bw(CTRL_OFS, 32'h0015, 4'h3);
        repeat (4) @(posedge core_clk);
        chkPin(pwmOut, 2'h3);
    endtask
    task automatic t_mask;
        logic [31:0] d;
        bw(MASK_OFS, 32'h1, 4'h1);
        br(MASK_OFS, d);
        chkReg(32'(d[3:2]), 32'h1);
        bw(SYNC_OFS, 32'h0e, 4'h1);
        bw(MASK_OFS, 32'h2, 4'h1);
        br(MASK_OFS, d);
        chkReg(32'(d[3:2]), 32'h1);
        bw(SYNC_OFS, 32'h1e, 4'h1);
        br(MASK_OFS, d);
        chkReg(32'(d[3:2]), 32'h2);
    endtask

    task automatic t_center;
        bw(CTRL_OFS, 32'h07c9, 4'h3);
        waitHit(16'h0000);
        wv(MATCH0 + 1, 16'h0005);
        wv(MOD_IDX, 16'h0004);
        expv(MATCH0 + 1, 16'h0000);
        waitHit(16'h0002);
        expv(MOD_IDX, 16'h0002);
        expv(MATCH0 + 1, 16'h0005);
        waitHit(16'h0001);
        expv(MOD_IDX, 16'h0004);
    endtask

    task automatic final_report;
        if (fails == 0 && testsRun > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Hang guard, well above the longest expected run
    initial begin
        repeat (20000) @(posedge core_clk);
        fails++;
        final_report();
    end

    initial begin
        resetn = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 6'h00;
        writedata = 32'h0;
        byteenable = 4'h0;
        fails = 0;
        testsRun = 0;
        repeat (10) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        t_reset();
        t_clock_off();
        t_legacy_wrap();
        t_ext_hw();
        t_restart();
        t_no_bound();
        t_match_sync();
        t_pair();
        t_mask();
        t_center();
        final_report();
    end
endmodule
